// ### oesc_pkg.sv
// Constants for the oscillator enable and stability controller
package oesc_pkg;
   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [11:0] SYS_CTRL_ONE_OFS  = 12'h000;
   localparam logic [11:0] FAST_EXT_CTRL_OFS = 12'h004;
   localparam logic [11:0] FAST_RC_CTRL_OFS  = 12'h008;
   localparam logic [11:0] SLOW_EXT_CTRL_OFS = 12'h00C;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int RC_EN_BIT     = 0;
   localparam int FAST_EN_BIT   = 1;
   localparam int SLOW_EN_BIT   = 2;
   localparam int LOCK_BIT      = 3;
   localparam int WAIT_LSB      = 0;
   localparam int DRIVE_LSB     = 2;
   localparam int FAST_MODE_BIT = 4;
   localparam int FAST_STB_BIT  = 5;
   localparam int DIV_LSB       = 0;
   localparam int RC_STB_BIT    = 5;
   localparam int AMP_LSB       = 4;
   localparam int SLOW_MODE_BIT = 6;
   localparam int SLOW_STB_BIT  = 7;
   // ****************************************
   // Reset values and divider code limit
   // ****************************************
   localparam logic [1:0] WAIT_RST   = 2'h2;
   localparam logic [1:0] DRIVE_RST  = 2'h0;
   localparam logic [1:0] AMP_RST    = 2'h0;
   localparam logic [3:0] DIV_RST    = 4'h3;
   localparam logic [3:0] DIV_MAX    = 4'h8;
   // ****************************************
   // Stability counts in oscillator edges
   // ****************************************
   localparam logic [18:0] FAST_CNT0 = 19'h02000;
   localparam logic [18:0] FAST_CNT1 = 19'h08000;
   localparam logic [18:0] FAST_CNT2 = 19'h20000;
   localparam logic [18:0] FAST_CNT3 = 19'h40000;
   localparam logic [18:0] SLOW_CNT0 = 19'h00100;
   localparam logic [18:0] SLOW_CNT1 = 19'h00400;
   localparam logic [18:0] SLOW_CNT2 = 19'h01000;
   localparam logic [18:0] SLOW_CNT3 = 19'h04000;
   localparam logic [18:0] RC_CNT    = 19'h00040;
   // ****************************************
   // Bus responses
   // ****************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### oesc_ctrl.sv
// Oscillator enable, stability detection and internal clock divider
// Function
// - Fast external oscillator off until enabled
// - Fast stability counts 8192 to 262144 edges
// - Fast stable flag reads detection result
// - Internal RC runs at reset, stops on 0
// - RC stable flag zero until restart detected
// - RC divided by 1,2,4..16, default 6
// - Slow mode: 0 crystal, 1 clock input
// - Slow external oscillator off until enabled
// - Slow stability counts 256 to 16384 edges
// - Slow stable flag reads detection result
// - Lock blocks clearing slow oscillator enable
// - Lock inactive at reset, set by 1
// - Slow drive and amplitude, four levels each
// - Fast mode: 0 crystal, 1 clock input
// - Stable flag cleared off, set when stable
module oesc_ctrl
   import oesc_pkg::*;
#(
   parameter int unsigned STAB_SHIFT = 0
)
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Oscillator outputs seen by the monitor
   input  wire logic        fast_crystal_in_pin,
   input  wire logic        fast_int_rc_clk,
   input  wire logic        slow_crystal_in_pin,
   // Oscillator controls
   output      logic        fast_ext_osc_enable,
   output      logic        fast_ext_mode,
   output      logic [1:0]  fast_drive_strength,
   output      logic        fast_int_rc_enable,
   output      logic        slow_ext_osc_enable,
   output      logic        slow_ext_mode,
   output      logic [1:0]  slow_drive_strength,
   output      logic [1:0]  slow_amplitude_select,
   output      logic        divided_internal_clock
);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [18:0] thr_f(input logic [1:0] sel, input logic slow);
      logic [18:0] b;
      unique case (sel)
         2'h0:    b = slow ? SLOW_CNT0 : FAST_CNT0;
         2'h1:    b = slow ? SLOW_CNT1 : FAST_CNT1;
         2'h2:    b = slow ? SLOW_CNT2 : FAST_CNT2;
         default: b = slow ? SLOW_CNT3 : FAST_CNT3;
      endcase
      b = b >> STAB_SHIFT;
      return (b == 19'h0) ? 19'h1 : b;
   endfunction

   // Half period in RC edges; factor 1 is a straight pass
   function automatic logic [3:0] half_f(input logic [3:0] code);
      logic [3:0] c;
      c = (code > DIV_MAX) ? DIV_MAX : code;
      return (c == 4'h0) ? 4'h1 : c;
   endfunction

   // ****************************************
   // State
   // ****************************************
   logic        awready_q, awready_d, wready_q, wready_d;
   logic        bvalid_q, bvalid_d, arready_q, arready_d;
   logic        rvalid_q, rvalid_d;
   logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d, wdat_q, wdat_d;
   logic [11:0] waddr_q, waddr_d;
   logic        aw_h_q, aw_h_d, w_h_q, w_h_d, wstb_q, wstb_d;
   logic        fe_en_q, fe_en_d, rc_en_q, rc_en_d, se_en_q, se_en_d;
   logic        lock_q, lock_d, fmode_q, fmode_d, smode_q, smode_d;
   logic [1:0]  fwait_q, fwait_d, fdrv_q, fdrv_d;
   logic [1:0]  swait_q, swait_d, sdrv_q, sdrv_d, samp_q, samp_d;
   logic [3:0]  div_q, div_d, dcnt_q, dcnt_d;
   logic        dclk_q, dclk_d;
   logic [2:0]  s1_q, s2_q, s3_q, stb_q, stb_d;
   logic [18:0] cnt_q [3];
   logic [18:0] cnt_d [3];
   logic [18:0] thr [3];
   logic [2:0]  en, edg;
   logic [31:0] rmux;

   // ****************************************
   // Input synchronisers
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
         s3_q <= 3'h0;
      end
      else
      begin
         s1_q <= {slow_crystal_in_pin, fast_int_rc_clk, fast_crystal_in_pin};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_comb
   begin
      en   = {se_en_q, rc_en_q, fe_en_q};
      edg  = s2_q & ~s3_q;
      thr[0] = thr_f(fwait_q, 1'b0);
      thr[1] = RC_CNT;
      thr[2] = thr_f(swait_q, 1'b1);
      rmux = 32'h0;
      unique case (s_axi_araddr)
         SYS_CTRL_ONE_OFS:
         begin
            rmux[RC_EN_BIT]   = rc_en_q;
            rmux[FAST_EN_BIT] = fe_en_q;
            rmux[SLOW_EN_BIT] = se_en_q;
            rmux[LOCK_BIT]    = lock_q;
         end
         FAST_EXT_CTRL_OFS:
         begin
            rmux[WAIT_LSB+:2]   = fwait_q;
            rmux[DRIVE_LSB+:2]  = fdrv_q;
            rmux[FAST_MODE_BIT] = fmode_q;
            rmux[FAST_STB_BIT]  = stb_q[0];
         end
         FAST_RC_CTRL_OFS:
         begin
            rmux[DIV_LSB+:4]  = div_q;
            rmux[RC_STB_BIT]  = stb_q[1];
         end
         SLOW_EXT_CTRL_OFS:
         begin
            rmux[WAIT_LSB+:2]   = swait_q;
            rmux[DRIVE_LSB+:2]  = sdrv_q;
            rmux[AMP_LSB+:2]    = samp_q;
            rmux[SLOW_MODE_BIT] = smode_q;
            rmux[SLOW_STB_BIT]  = stb_q[2];
         end
         default: rmux = 32'h0;
      endcase
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      {aw_h_d, w_h_d, waddr_d, wdat_d, wstb_d} = {aw_h_q, w_h_q, waddr_q, wdat_q, wstb_q};
      {bvalid_d, bresp_d, rvalid_d, rresp_d, rdata_d} =
         {bvalid_q, bresp_q, rvalid_q, rresp_q, rdata_q};
      {fe_en_d, rc_en_d, se_en_d, lock_d} = {fe_en_q, rc_en_q, se_en_q, lock_q};
      {fwait_d, fdrv_d, fmode_d, div_d} = {fwait_q, fdrv_q, fmode_q, div_q};
      {swait_d, sdrv_d, samp_d, smode_d} = {swait_q, sdrv_q, samp_q, smode_q};
      if (s_axi_awvalid && awready_q)
      begin
         aw_h_d  = 1'b1;
         waddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q)
      begin
         w_h_d  = 1'b1;
         wdat_d = s_axi_wdata;
         wstb_d = s_axi_wstrb[0];
      end
      if (bvalid_q && s_axi_bready)
         bvalid_d = 1'b0;
      // One write at a time: the response must drain first
      if (aw_h_d && w_h_d && !bvalid_q)
      begin
         aw_h_d   = 1'b0;
         w_h_d    = 1'b0;
         bvalid_d = 1'b1;
         bresp_d  = RESP_OKAY;
         unique case (waddr_d)
            SYS_CTRL_ONE_OFS:
            if (wstb_d)
            begin
               rc_en_d = wdat_d[RC_EN_BIT];
               fe_en_d = wdat_d[FAST_EN_BIT];
               if (wdat_d[SLOW_EN_BIT] || !lock_q)
                  se_en_d = wdat_d[SLOW_EN_BIT];
               if (wdat_d[LOCK_BIT])
                  lock_d = 1'b1;
            end
            FAST_EXT_CTRL_OFS:
            if (wstb_d)
            begin
               fwait_d = wdat_d[WAIT_LSB+:2];
               fdrv_d  = wdat_d[DRIVE_LSB+:2];
               fmode_d = wdat_d[FAST_MODE_BIT];
            end
            FAST_RC_CTRL_OFS:
            if (wstb_d)
               div_d = wdat_d[DIV_LSB+:4];
            SLOW_EXT_CTRL_OFS:
            if (wstb_d)
            begin
               swait_d = wdat_d[WAIT_LSB+:2];
               sdrv_d  = wdat_d[DRIVE_LSB+:2];
               samp_d  = wdat_d[AMP_LSB+:2];
               smode_d = wdat_d[SLOW_MODE_BIT];
            end
            default: bresp_d = RESP_SLVERR;
         endcase
      end
      awready_d = !aw_h_d && !bvalid_d;
      wready_d  = !w_h_d && !bvalid_d;
      if (rvalid_q && s_axi_rready)
         rvalid_d = 1'b0;
      if (s_axi_arvalid && arready_q)
      begin
         rvalid_d = 1'b1;
         rdata_d  = rmux;
         rresp_d  = (rmux == 32'h0 && s_axi_araddr > SLOW_EXT_CTRL_OFS) ||
                    (s_axi_araddr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end
      arready_d = !rvalid_d;
      // Stability counters, cleared whenever the oscillator is off
      for (int i = 0; i < 3; i++)
      begin
         if (!en[i])
            cnt_d[i] = 19'h0;
         else if (edg[i] && cnt_q[i] < thr[i])
            cnt_d[i] = cnt_q[i] + 19'h1;
         else
            cnt_d[i] = cnt_q[i];
         stb_d[i] = en[i] && (cnt_d[i] >= thr[i]);
      end
      // Divider held low while the RC is off, so a restart begins on a full phase
      dcnt_d = dcnt_q;
      dclk_d = dclk_q;
      if (!rc_en_q)
      begin
         dcnt_d = 4'h0;
         dclk_d = 1'b0;
      end
      else if (div_q == 4'h0)
         dclk_d = s2_q[1];
      else if (edg[1])
      begin
         if (dcnt_q >= half_f(div_q) - 4'h1)
         begin
            dcnt_d = 4'h0;
            dclk_d = !dclk_q;
         end
         else
            dcnt_d = dcnt_q + 4'h1;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         {awready_q, wready_q, bvalid_q, arready_q, rvalid_q} <= 5'h0;
         {bresp_q, rresp_q} <= 4'h0;
         {rdata_q, wdat_q} <= 64'h0;
         {aw_h_q, w_h_q, wstb_q} <= 3'h0;
         waddr_q <= 12'h000;
         {fe_en_q, se_en_q, lock_q} <= 3'h0;
         rc_en_q <= 1'b1;
         {fmode_q, smode_q} <= 2'h0;
         {fwait_q, swait_q} <= {WAIT_RST, WAIT_RST};
         {fdrv_q, sdrv_q, samp_q} <= {DRIVE_RST, DRIVE_RST, AMP_RST};
         div_q <= DIV_RST;
         {dcnt_q, dclk_q} <= 5'h00;
         stb_q <= 3'h0;
         for (int i = 0; i < 3; i++)
            cnt_q[i] <= 19'h0;
      end
      else
      begin
         {awready_q, wready_q, bvalid_q, arready_q, rvalid_q} <=
            {awready_d, wready_d, bvalid_d, arready_d, rvalid_d};
         {bresp_q, rresp_q} <= {bresp_d, rresp_d};
         {rdata_q, wdat_q} <= {rdata_d, wdat_d};
         {aw_h_q, w_h_q, wstb_q} <= {aw_h_d, w_h_d, wstb_d};
         waddr_q <= waddr_d;
         {fe_en_q, rc_en_q, se_en_q, lock_q} <= {fe_en_d, rc_en_d, se_en_d, lock_d};
         {fmode_q, smode_q} <= {fmode_d, smode_d};
         {fwait_q, swait_q} <= {fwait_d, swait_d};
         {fdrv_q, sdrv_q, samp_q} <= {fdrv_d, sdrv_d, samp_d};
         div_q <= div_d;
         {dcnt_q, dclk_q} <= {dcnt_d, dclk_d};
         stb_q <= stb_d;
         for (int i = 0; i < 3; i++)
            cnt_q[i] <= cnt_d[i];
      end
   end

   assign s_axi_awready          = awready_q;
   assign s_axi_wready           = wready_q;
   assign s_axi_bvalid           = bvalid_q;
   assign s_axi_bresp            = bresp_q;
   assign s_axi_arready          = arready_q;
   assign s_axi_rvalid           = rvalid_q;
   assign s_axi_rdata            = rdata_q;
   assign s_axi_rresp            = rresp_q;
   assign fast_ext_osc_enable    = fe_en_q;
   assign fast_ext_mode          = fmode_q;
   assign fast_drive_strength    = fdrv_q;
   assign fast_int_rc_enable     = rc_en_q;
   assign slow_ext_osc_enable    = se_en_q;
   assign slow_ext_mode          = smode_q;
   assign slow_drive_strength    = sdrv_q;
   assign slow_amplitude_select  = samp_q;
   assign divided_internal_clock = dclk_q;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_rc_off_on;
      !rc_en_q ##1 rc_en_q;
   endsequence

   a_reset_defaults: assert property (!$past(aresetn) |->
      !fe_en_q && rc_en_q && !se_en_q && !lock_q && div_q == DIV_RST)
      else $error("oscillator defaults wrong after reset");
   a_fast_off_clear: assert property (!fe_en_q |=> !stb_q[0])
      else $error("fast stable flag set while disabled");
   a_fast_count: assert property ($rose(stb_q[0]) |-> cnt_q[0] == thr[0])
      else $error("fast stable flag rose before full count");
   a_slow_count: assert property ($rose(stb_q[2]) |-> cnt_q[2] == thr[2])
      else $error("slow stable flag rose before full count");
   a_slow_off_clear: assert property (!se_en_q ##1 !se_en_q |-> !stb_q[2])
      else $error("slow stable flag set while disabled");
   a_lock_hold_en: assert property (lock_q && se_en_q |=> se_en_q)
      else $error("locked slow oscillator was stopped");
   a_lock_sticky: assert property (lock_q |=> lock_q)
      else $error("slow enable lock dropped");
   a_rc_restart: assert property (s_rc_off_on |-> !stb_q[1] ##1 !stb_q[1])
      else $error("rc stable flag high right after restart");
   a_div_gated: assert property (!rc_en_q |=> !dclk_q && dcnt_q == 4'h0)
      else $error("divided clock not gated while rc off");
endmodule

// ### oesc_osc_model.sv
// Behavioural oscillator that stands in for a crystal or an external clock source
module oesc_osc_model
#(
   parameter int HALF_NS = 100
)
(
   // Control and output
   input  wire logic enable,
   output      logic pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // Offset keeps oscillator edges away from bus clock edges
   always
   begin
      pin = 1'b0;
      wait (enable === 1'b1);
      #13;
      while (enable === 1'b1)
      begin
         #HALF_NS;
         pin = enable ? ~pin : 1'b0;
      end
   end
endmodule

// ### tb.sv
// Self-checking testbench of the oscillator enable and stability controller
module tb import oesc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // ********
   // Signals
   // ********
   localparam int SHIFT = 8;
   localparam int FN[4] = '{8192, 32768, 131072, 262144};
   localparam int SN[4] = '{256, 1024, 4096, 16384};
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, fast_crystal_in_pin, fast_int_rc_clk, slow_crystal_in_pin;
   logic        fast_ext_osc_enable, fast_ext_mode, fast_int_rc_enable, slow_ext_osc_enable;
   logic        slow_ext_mode, divided_internal_clock;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rnd, rdv;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [1:0]  fast_drive_strength, slow_drive_strength, slow_amplitude_select;
   logic [7:0]  sys_v, dv;
   int          err_count, compares, per;

   oesc_ctrl #(.STAB_SHIFT(SHIFT)) i_dut
   (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .fast_crystal_in_pin, .fast_int_rc_clk, .slow_crystal_in_pin,
      .fast_ext_osc_enable, .fast_ext_mode, .fast_drive_strength, .fast_int_rc_enable,
      .slow_ext_osc_enable, .slow_ext_mode, .slow_drive_strength, .slow_amplitude_select,
      .divided_internal_clock
   );
   oesc_osc_model #(.HALF_NS(100)) i_fast (.enable(fast_ext_osc_enable), .pin(fast_crystal_in_pin));
   oesc_osc_model #(.HALF_NS(100)) i_rc (.enable(fast_int_rc_enable), .pin(fast_int_rc_clk));
   oesc_osc_model #(.HALF_NS(250)) i_slow (.enable(slow_ext_osc_enable), .pin(slow_crystal_in_pin));

   initial
   begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   // ********
   // Helpers
   // ********
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic int stab(input logic slow, input logic [1:0] c);
      int t;
      t = (slow ? SN[c] : FN[c]) >> SHIFT;
      return (t < 1) ? 1 : t;
   endfunction
   function automatic int factor(input int c);
      return (c == 0) ? 1 : 2 * c;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
         err_count++;
      end
   endtask
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic bound(input int n, input int lim);
      if (n >= lim)
      begin
         err_count++;
         conclude();
      end
   endtask
   // Write and read hold every channel until its own handshake edge
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1 && n < 200);
      bound(n, 200);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1 && n < 200);
      bound(n, 200);
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic poll(input logic [11:0] a, input int b, input int lim);
      int n;
      n = 0;
      do
      begin
         rd(a);
         n++;
      end
      while (rdv[b] !== 1'b1 && n < lim);
      bound(n, lim);
   endtask
   // Cycles up to the next rising edge of the divided clock
   task automatic rise(output int n);
      n = 0;
      do begin @(posedge aclk); n++; end while (divided_internal_clock !== 1'b0 && n < 400);
      do begin @(posedge aclk); n++; end while (divided_internal_clock !== 1'b1 && n < 400);
      bound(n, 400);
   endtask
   // Parameters are written only while the oscillator is stopped
   task automatic osc_run(input logic slow, input logic [1:0] code);
      logic [7:0]  cfg;
      logic [11:0] ofs;
      int          b, h, t;
      rnd = lfsr(rnd);
      cfg = slow ? {1'b0, rnd[2], rnd[4:3], rnd[6:5], code} : {3'h0, rnd[2], rnd[4:3], code};
      ofs = slow ? SLOW_EXT_CTRL_OFS : FAST_EXT_CTRL_OFS;
      b = slow ? SLOW_STB_BIT : FAST_STB_BIT;
      h = slow ? 5 : 2;
      t = stab(slow, code);
      wr(ofs, {24'h0, cfg}, 4'hF);
      if (slow)
         check({slow_ext_mode, slow_amplitude_select, slow_drive_strength}, cfg[6:2]);
      else
         check({fast_ext_mode, fast_drive_strength}, cfg[4:2]);
      sys_v[slow ? SLOW_EN_BIT : FAST_EN_BIT] = 1'b1;
      wr(SYS_CTRL_ONE_OFS, {24'h0, sys_v}, 4'h1);
      check(slow ? slow_ext_osc_enable : fast_ext_osc_enable, 32'h1);
      if (t >= 4)
      begin
         repeat ((2 * t - 4) * h - 6) @(posedge aclk);
         rd(ofs);
         check(rdv, {24'h0, cfg});
      end
      poll(ofs, b, t * h + 20);
      check(rdv, {24'h0, cfg} | (32'h1 << b));
      sys_v[slow ? SLOW_EN_BIT : FAST_EN_BIT] = 1'b0;
      wr(SYS_CTRL_ONE_OFS, {24'h0, sys_v}, 4'h1);
      check(slow ? slow_ext_osc_enable : fast_ext_osc_enable, 32'h0);
      rd(ofs);
      check(rdv, {24'h0, cfg});
   endtask
   // ********
   // Sequence
   // ********
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
      err_count = 0;
      compares = 0;
      rnd = 32'h1E0A;
      sys_v = 8'h01;
      dv = 8'h03;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check({fast_ext_osc_enable, fast_int_rc_enable, slow_ext_osc_enable}, 3'h2);
      rd(SYS_CTRL_ONE_OFS);
      check(rdv, 32'h01);
      rd(FAST_EXT_CTRL_OFS);
      check(rdv, 32'h02);
      rd(FAST_RC_CTRL_OFS);
      check(rdv, 32'h03);
      rd(SLOW_EXT_CTRL_OFS);
      check(rdv, 32'h02);
      poll(FAST_RC_CTRL_OFS, RC_STB_BIT, 150);
      rise(per);
      rise(per);
      check(per, 32'd24);
      $display("Test reset done");
      wr(12'h010, 32'hFF, 4'hF);
      check(rsp, RESP_SLVERR);
      rd(12'h010);
      check(rdv, 32'h0);
      check(rsp, RESP_SLVERR);
      rd(12'h002);
      check(rsp, RESP_SLVERR);
      wr(FAST_EXT_CTRL_OFS, 32'hFF, 4'h0);
      rd(FAST_EXT_CTRL_OFS);
      check(rdv, 32'h02);
      check(rsp, RESP_OKAY);
      $display("Test bus done");
      for (int c = 0; c < 8; c++)
         osc_run(c[2], c[1:0]);
      $display("Test stability done");
      for (int c = 0; c <= 8; c++)
      begin
         sys_v[RC_EN_BIT] = 1'b0;
         wr(SYS_CTRL_ONE_OFS, {24'h0, sys_v}, 4'h1);
         repeat (8) @(posedge aclk);
         check({fast_int_rc_enable, divided_internal_clock}, 2'h0);
         rd(FAST_RC_CTRL_OFS);
         check(rdv, {24'h0, dv});
         dv = 8'(c);
         wr(FAST_RC_CTRL_OFS, {24'h0, dv}, 4'hF);
         sys_v[RC_EN_BIT] = 1'b1;
         wr(SYS_CTRL_ONE_OFS, {24'h0, sys_v}, 4'h1);
         poll(FAST_RC_CTRL_OFS, RC_STB_BIT, 150);
         rise(per);
         rise(per);
         check(per, 4 * factor(c));
      end
      $display("Test divider done");
      wr(SYS_CTRL_ONE_OFS, 32'h0D, 4'h1);
      wr(SYS_CTRL_ONE_OFS, 32'h09, 4'h1);
      check({rsp, slow_ext_osc_enable}, {RESP_OKAY, 1'b1});
      rd(SYS_CTRL_ONE_OFS);
      check(rdv, 32'h0D);
      // Only a reset releases the lock
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(SYS_CTRL_ONE_OFS);
      check(rdv, 32'h01);
      rd(SLOW_EXT_CTRL_OFS);
      check(rdv, 32'h02);
      $display("Test lock done");
      conclude();
   end
endmodule
